/* verilog/fnd_defines.svh */
// Purpose: Offsets, field positions, reset values and timing for fnd
// Assumes: 24-bit register words, 6-bit register address
// Notes:   Definitions only
`ifndef FND_DEFINES_SVH
`define FND_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FND_OFF_VERSION 6'h00
`define FND_OFF_ENABLE  6'h01
`define FND_OFF_REFDIV  6'h02
`define FND_OFF_INTWORD 6'h03
`define FND_OFF_FRAC    6'h04
`define FND_OFF_MODCFG  6'h06
`define FND_OFF_OUTCFG  6'h08
`define FND_OFF_EXACT   6'h0c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FND_EN_SRC_PIN   0
`define FND_EN_SOFT      1
`define FND_EN_OVR_LSB   2
`define FND_CFG_SEED_MSB 1
`define FND_CFG_VARIANT  2
`define FND_CFG_INTSEL   7
`define FND_CFG_AUTOSEED 8
`define FND_CFG_DSM_EN   11
`define FND_OUT_DIV2     19

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define FND_RST_ENABLE  24'h000001
`define FND_RST_REFDIV  24'h000001
`define FND_RST_INTWORD 24'h000019
`define FND_RST_FRAC    24'h000000
`define FND_RST_MODCFG  24'h000182
`define FND_RST_OUTCFG  24'h000000
`define FND_RST_EXACT   24'h000000
`define FND_REFDIV_MAX  15'h4000
`define FND_SEED0       24'h000000
`define FND_SEED1       24'h400000
`define FND_SEED2       24'hb3a5c1
`define FND_SEED3       24'h5a3c96

// ----------------------------------------
// Timing
// ----------------------------------------
`define FND_CLK_PERIOD_NS 25
`define FND_POR_US        250
`define FND_POR_CYCLES    ((`FND_POR_US * 1000 + `FND_CLK_PERIOD_NS - 1) / `FND_CLK_PERIOD_NS)

`endif

/* verilog/fnd_pkg.sv */
// Purpose: Types shared by the divider control block
// Assumes: Constants live in fnd_defines.svh
// Notes:   Types only
`default_nettype none
package fnd_pkg;
	// Register access as delivered by the serial port
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [5:0]  addr;
		logic [23:0] data;
	} fnd_req_t;

	// Decoded modulator status
	typedef struct packed {
		logic mod_on;
		logic variant_b;
		logic exact;
		logic div2;
	} fnd_mode_t;

	typedef enum logic [1:0] {DSM_INT, DSM_FRAC, DSM_OFF} fnd_dsm_t;
	typedef enum logic {POR_HOLD, POR_RUN} fnd_por_t;
endpackage
`default_nettype wire

/* verilog/fnd_divider_ctrl.sv */
// Purpose: Register file and feedback divider control of a frac-N synth
// Assumes: Register port already deserialised, on REF_CLK
// Notes:   RST is the power-on reset from the supply monitor
`include "fnd_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fnd_divider_ctrl
	import fnd_pkg::*;
#(
	parameter int          POR_CYCLES = `FND_POR_CYCLES,
	parameter int          NBLK       = 4,
	parameter logic [23:0] VERSION    = 24'h0a5701 // Arbitrary value
) (
	// Clock and power-on reset
	input  wire logic              REF_CLK,
	input  wire logic              RST,
	// Register port
	input  wire fnd_req_t          REG_REQ,
	output logic [23:0]            REG_RDATA,
	output logic                   REG_RVALID,
	// Enable pin
	input  wire logic              CHIP_ENABLE_PIN,
	// Divider control
	output logic                   PD_TICK,
	output logic [19:0]            FB_RATIO,
	output fnd_mode_t              MODE,
	// Power control and status
	output logic                   CHIP_EN,
	output logic [NBLK-1:0]        BLOCK_PWR,
	output logic                   POR_DONE
);

	localparam int PW = $clog2(POR_CYCLES + 1);

	// ----------------------------------------
	// Power-on hold
	// ----------------------------------------
	fnd_por_t    por_reg;
	logic [PW-1:0] por_cnt_reg;
	logic          run;

	// Registers stay at defaults until the supply has settled
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			por_reg     <= POR_HOLD;
			por_cnt_reg <= '0;
		end else begin
			case (por_reg)
				POR_HOLD: begin
					por_cnt_reg <= por_cnt_reg + PW'(1);
					if (por_cnt_reg == PW'(POR_CYCLES - 1))
						por_reg <= POR_RUN;
				end
				default: por_cnt_reg <= por_cnt_reg;
			endcase
		end
	end
	assign run      = (por_reg == POR_RUN);
	assign POR_DONE = run;

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [23:0] en_reg, refdiv_reg, int_reg, frac_reg;
	logic [23:0] cfg_reg, out_reg, exact_reg;
	logic        wr_ok, frac_wr;

	// Writes are ignored while the reset hold runs
	assign wr_ok   = REG_REQ.wr && run;
	assign frac_wr = wr_ok && (REG_REQ.addr == `FND_OFF_FRAC);

	// One 24-bit word per address
	always_ff @(posedge REF_CLK) begin
		if (RST || !run) begin
			en_reg     <= `FND_RST_ENABLE;
			refdiv_reg <= `FND_RST_REFDIV;
			int_reg    <= `FND_RST_INTWORD;
			frac_reg   <= `FND_RST_FRAC;
			cfg_reg    <= `FND_RST_MODCFG;
			out_reg    <= `FND_RST_OUTCFG;
			exact_reg  <= `FND_RST_EXACT;
		end else if (wr_ok) begin
			if (REG_REQ.addr == `FND_OFF_ENABLE)
				en_reg <= REG_REQ.data;
			else if (REG_REQ.addr == `FND_OFF_REFDIV)
				refdiv_reg <= REG_REQ.data;
			else if (REG_REQ.addr == `FND_OFF_INTWORD)
				int_reg <= REG_REQ.data;
			else if (REG_REQ.addr == `FND_OFF_FRAC)
				frac_reg <= REG_REQ.data;
			else if (REG_REQ.addr == `FND_OFF_MODCFG)
				cfg_reg <= REG_REQ.data;
			else if (REG_REQ.addr == `FND_OFF_OUTCFG)
				out_reg <= REG_REQ.data;
			else if (REG_REQ.addr == `FND_OFF_EXACT)
				exact_reg <= REG_REQ.data;
		end
	end

	// Read port: one cycle latency, unmapped reads return zero
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			REG_RDATA  <= 24'h000000;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RVALID <= REG_REQ.rd;
			if (!REG_REQ.rd)
				REG_RDATA <= REG_RDATA;
			else if (REG_REQ.addr == `FND_OFF_VERSION)
				REG_RDATA <= VERSION;
			else if (REG_REQ.addr == `FND_OFF_ENABLE)
				REG_RDATA <= en_reg;
			else if (REG_REQ.addr == `FND_OFF_REFDIV)
				REG_RDATA <= refdiv_reg;
			else if (REG_REQ.addr == `FND_OFF_INTWORD)
				REG_RDATA <= int_reg;
			else if (REG_REQ.addr == `FND_OFF_FRAC)
				REG_RDATA <= frac_reg;
			else if (REG_REQ.addr == `FND_OFF_MODCFG)
				REG_RDATA <= cfg_reg;
			else if (REG_REQ.addr == `FND_OFF_OUTCFG)
				REG_RDATA <= out_reg;
			else if (REG_REQ.addr == `FND_OFF_EXACT)
				REG_RDATA <= exact_reg;
			else
				REG_RDATA <= 24'h000000;
		end
	end

	// ----------------------------------------
	// Chip enable and block overrides
	// ----------------------------------------
	logic pin_s1_reg, pin_s2_reg, chip_en_next;

	// Pin is asynchronous to REF_CLK
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
		end else begin
			pin_s1_reg <= CHIP_ENABLE_PIN;
			pin_s2_reg <= pin_s1_reg;
		end
	end

	assign chip_en_next = en_reg[`FND_EN_SRC_PIN] ? pin_s2_reg : en_reg[`FND_EN_SOFT];

	always_ff @(posedge REF_CLK) begin
		if (RST)
			CHIP_EN <= 1'b0;
		else
			CHIP_EN <= chip_en_next;
	end

	// Each block runs when the chip is on or its override is set
	genvar gi;
	generate
		for (gi = 0; gi < NBLK; gi++) begin : g_pwr
			always_ff @(posedge REF_CLK) begin
				if (RST)
					BLOCK_PWR[gi] <= 1'b0;
				else
					BLOCK_PWR[gi] <= chip_en_next | en_reg[`FND_EN_OVR_LSB + gi];
			end
		end
	endgenerate

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	fnd_dsm_t dsm;
	logic     exact_ok;

	// Matching bit pairs (both set or both clear) leave the modulator off and the integer word in use
	always_comb begin
		if (!cfg_reg[`FND_CFG_DSM_EN] && cfg_reg[`FND_CFG_INTSEL])
			dsm = DSM_INT;
		else if (cfg_reg[`FND_CFG_DSM_EN] && !cfg_reg[`FND_CFG_INTSEL])
			dsm = DSM_FRAC;
		else
			dsm = DSM_OFF;
	end
	assign exact_ok = (dsm == DSM_FRAC) && cfg_reg[`FND_CFG_VARIANT]
		&& (exact_reg[13:0] != 14'h0000);

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			MODE <= '0;
		end else begin
			MODE.mod_on    <= (dsm == DSM_FRAC);
			MODE.variant_b <= cfg_reg[`FND_CFG_VARIANT];
			MODE.exact     <= exact_ok;
			MODE.div2      <= out_reg[`FND_OUT_DIV2];
		end
	end

	// ----------------------------------------
	// Reference divider
	// ----------------------------------------
	logic [14:0] r_eff, ref_cnt_reg;

	// Zero is treated as one, anything past 2^14 as 2^14
	always_comb begin
		if (refdiv_reg[14:0] == 15'h0000)
			r_eff = 15'h0001;
		else if (refdiv_reg[14:0] > `FND_REFDIV_MAX)
			r_eff = `FND_REFDIV_MAX;
		else
			r_eff = refdiv_reg[14:0];
	end

	always_ff @(posedge REF_CLK) begin
		if (RST || !run) begin
			ref_cnt_reg <= 15'h0000;
			PD_TICK     <= 1'b0;
		end else if (ref_cnt_reg >= r_eff - 15'h0001) begin
			ref_cnt_reg <= 15'h0000;
			PD_TICK     <= 1'b1;
		end else begin
			ref_cnt_reg <= ref_cnt_reg + 15'h0001;
			PD_TICK     <= 1'b0;
		end
	end

	// ----------------------------------------
	// Delta-sigma modulator
	// ----------------------------------------
	logic [23:0] acc1_reg, acc2_reg, seed;
	logic [24:0] sum1, sum2;
	logic        c2_d_reg, ex_wrap;
	logic [13:0] ex_cnt_reg;
	logic [20:0] ratio_a, ratio_b;

	// Preset start phases
	always_comb begin
		case (cfg_reg[`FND_CFG_SEED_MSB:0])
			2'h0:    seed = `FND_SEED0;
			2'h1:    seed = `FND_SEED1;
			2'h2:    seed = `FND_SEED2;
			default: seed = `FND_SEED3;
		endcase
	end

	assign sum1 = {1'b0, acc1_reg} + {1'b0, frac_reg};
	assign sum2 = {1'b0, acc2_reg} + {1'b0, sum1[23:0]};
	assign ex_wrap = exact_ok && (ex_cnt_reg >= exact_reg[13:0] - 14'h0001);

	// Variant B is a two-stage cascade, wider dither but cleaner far out
	assign ratio_a = {2'b00, int_reg[18:0]} + {20'h00000, sum1[24]};
	assign ratio_b = ratio_a + {20'h00000, sum2[24]} - {20'h00000, c2_d_reg};

	// Phase accumulators: a seed reload beats a comparison tick
	always_ff @(posedge REF_CLK) begin
		if (RST || !run) begin
			acc1_reg   <= `FND_SEED0;
			acc2_reg   <= `FND_SEED0;
			c2_d_reg   <= 1'b0;
			ex_cnt_reg <= 14'h0000;
		end else if (frac_wr && cfg_reg[`FND_CFG_AUTOSEED]) begin
			acc1_reg   <= seed;
			acc2_reg   <= seed;
			c2_d_reg   <= 1'b0;
			ex_cnt_reg <= 14'h0000;
		end else if (PD_TICK && dsm == DSM_FRAC) begin
			// Without autoseed the old phase simply carries on
			c2_d_reg <= sum2[24];
			if (ex_wrap) begin
				// Period of f_pd/ratio makes the step exact at full modulus
				acc1_reg   <= seed;
				acc2_reg   <= seed;
				ex_cnt_reg <= 14'h0000;
			end else begin
				acc1_reg   <= sum1[23:0];
				acc2_reg   <= sum2[23:0];
				ex_cnt_reg <= ex_cnt_reg + 14'h0001;
			end
		end
	end

	// Divide ratio applied at each comparison tick in fractional mode, every cycle in the other modes
	always_ff @(posedge REF_CLK) begin
		if (RST)
			FB_RATIO <= 20'h00000;
		else if (dsm != DSM_FRAC)
			FB_RATIO <= {1'b0, int_reg[18:0]};
		else if (PD_TICK)
			FB_RATIO <= cfg_reg[`FND_CFG_VARIANT] ? ratio_b[19:0] : ratio_a[19:0];
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	logic [14:0] gap_reg; // Cycles since last tick, cleared with the divider count
	always_ff @(posedge REF_CLK) begin
		if (RST || !run)
			gap_reg <= 15'h0000;
		else
			gap_reg <= PD_TICK ? 15'h0001 : gap_reg + 15'h0001;
	end

	sequence frac_wr_s;
		frac_wr && cfg_reg[`FND_CFG_AUTOSEED];
	endsequence
	sequence plain_wr_s;
		frac_wr && !cfg_reg[`FND_CFG_AUTOSEED] && !(PD_TICK && exact_ok);
	endsequence

	AST_INT_MODE: assert property (
		(!cfg_reg[11] && cfg_reg[7]) |=> !MODE.mod_on && FB_RATIO == {1'b0, $past(int_reg[18:0])})
		else $error("integer mode left the modulator running");
	AST_FRAC_MODE: assert property (
		(cfg_reg[11] && !cfg_reg[7]) |=> MODE.mod_on)
		else $error("fractional mode did not enable the modulator");
	AST_EXACT_B: assert property (
		MODE.exact |-> MODE.variant_b && MODE.mod_on)
		else $error("exact mode active outside variant B");
	AST_RATIO_A: assert property (
		(PD_TICK && dsm == DSM_FRAC && !cfg_reg[2])
		|=> FB_RATIO == $past(ratio_a[19:0]) && FB_RATIO - {1'b0, int_reg[18:0]} <= 20'h00001)
		else $error("variant A ratio wrong");
	AST_DIV2: assert property (
		(wr_ok && REG_REQ.addr == `FND_OFF_OUTCFG) |=> ##1 MODE.div2 == $past(REG_REQ.data[19], 2))
		else $error("divide by two does not follow bit 19");
	AST_REF_GAP: assert property (
		(PD_TICK && $past(PD_TICK) == 1'b0 && $stable(r_eff) && run) |-> gap_reg == r_eff)
		else $error("comparison tick spacing differs from divider ratio");
	AST_AUTOSEED: assert property (
		frac_wr_s |=> acc1_reg == $past(seed) && acc2_reg == $past(seed))
		else $error("autoseed did not reload the accumulator");
	AST_NO_RESEED: assert property (
		plain_wr_s |=> acc1_reg == $past(PD_TICK && dsm == DSM_FRAC ? sum1[23:0] : acc1_reg))
		else $error("accumulator changed without autoseed");
	AST_POR_HOLD: assert property (
		!run |=> cfg_reg == `FND_RST_MODCFG && frac_reg == `FND_RST_FRAC)
		else $error("registers left defaults during power-on hold");
	AST_CHIP_EN: assert property (
		!en_reg[0] ##1 !en_reg[0] |-> CHIP_EN == $past(en_reg[1]))
		else $error("soft enable not followed");
	AST_VERSION: assert property (
		(REG_REQ.rd && REG_REQ.addr == `FND_OFF_VERSION) |=> REG_RVALID && REG_RDATA == VERSION)
		else $error("version read returned wrong value");

endmodule // fnd_divider_ctrl
`default_nettype wire

/* bench/fnd_divider_ctrl_tb.sv */
// Purpose: Self-checking bench for the divider control block
// Assumes: Power-on hold shortened to 16 cycles, inputs driven on falling edge
// Notes:   Seed checks compare carry latencies, so pipeline depth cancels out
`include "fnd_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fnd_divider_ctrl_tb
	import fnd_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam logic [23:0] VER = 24'h3c6e29; // Arbitrary value
	logic        ref_clk = 1'b0;
	logic        rst     = 1'b1;
	fnd_req_t    req     = '0;
	logic        pin     = 1'b0;
	logic [23:0] rdata;
	logic        rvalid, tick, chip_en, por_done;
	logic [19:0] ratio;
	fnd_mode_t   mode;
	logic [3:0]  pwr;
	int          err_count    = 0;
	int          total_checks = 0;
	int          cyc_count    = 0;
	logic [5:0]  offs [8] = '{`FND_OFF_VERSION, `FND_OFF_ENABLE, `FND_OFF_REFDIV,
		`FND_OFF_INTWORD, `FND_OFF_FRAC, `FND_OFF_MODCFG, `FND_OFF_OUTCFG, `FND_OFF_EXACT};
	logic [23:0] dflt [8] = '{VER, `FND_RST_ENABLE, `FND_RST_REFDIV, `FND_RST_INTWORD,
		`FND_RST_FRAC, `FND_RST_MODCFG, `FND_RST_OUTCFG, `FND_RST_EXACT};
	logic [23:0] seeds [4] = '{`FND_SEED0, `FND_SEED1, `FND_SEED2, `FND_SEED3};

	// Device under test, hold shortened to keep the run brief
	fnd_divider_ctrl #(.POR_CYCLES(16), .NBLK(4), .VERSION(VER)) uut (
		.REF_CLK(ref_clk), .RST(rst), .REG_REQ(req), .REG_RDATA(rdata),
		.REG_RVALID(rvalid), .CHIP_ENABLE_PIN(pin), .PD_TICK(tick), .FB_RATIO(ratio),
		.MODE(mode), .CHIP_EN(chip_en), .BLOCK_PWR(pwr), .POR_DONE(por_done));

	// Clock, 25 ns period
	always #12.5 ref_clk = ~ref_clk;

	// Hang guard, longest test waits out close to three 16384-cycle tick gaps
	always @(posedge ref_clk) begin
		cyc_count <= cyc_count + 1;
		if (cyc_count == 80000) begin
			err_count++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wait_cycles(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// Write strobe lasts one cycle, taken at the rising edge in between
	task automatic wr(input logic [5:0] a, input logic [23:0] d);
		@(negedge ref_clk);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
		@(negedge ref_clk);
		req = '0;
	endtask

	// Read valid stands one cycle only, so it is looked at right then
	task automatic rd_chk(input logic [5:0] a, input logic [23:0] exp);
		@(negedge ref_clk);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, data: 24'h0};
		@(negedge ref_clk);
		req = '0;
		chk({23'h0, rvalid}, 24'h1);
		chk(rdata, exp);
	endtask

	function automatic logic [23:0] cfg(input logic dsm, intsel, auto, varb,
		input logic [1:0] seed);
		return {12'h0, dsm, 2'b00, auto, intsel, 4'h0, varb, seed};
	endfunction

	// Ticks until the accumulator first overflows with step 2^20
	function automatic int carry_ticks(input logic [23:0] s);
		return (32'h1000000 - {8'h0, s} + 32'h0fffff) >> 20;
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic por_test();
		rst = 1'b1;
		wait_cycles(10);
		chk({mode, ratio}, 24'h0);
		chk({22'h0, por_done, rvalid}, 24'h0);
		rst = 1'b0;
		wr(`FND_OFF_INTWORD, 24'h000030);
		wait_cycles(13);
		chk({3'h0, por_done, ratio}, 24'h000019);
		wait_cycles(1);
		chk({23'h0, por_done}, 24'h1);
		for (int i = 0; i < 8; i++) begin
			rd_chk(offs[i], dflt[i]);
		end
		$display("test por done");
	endtask

	task automatic reg_test();
		wr(`FND_OFF_VERSION, 24'h123456);
		rd_chk(`FND_OFF_VERSION, VER);
		rd_chk(6'h05, 24'h0);
		wr(`FND_OFF_FRAC, 24'hffffff);
		rd_chk(`FND_OFF_FRAC, 24'hffffff);
		wr(`FND_OFF_FRAC, 24'h0);
		$display("test registers done");
	endtask

	// With a zero fraction every mode must feed the plain integer word
	task automatic mode_test();
		wr(`FND_OFF_INTWORD, 24'h07fffb);
		for (int i = 0; i < 4; i++) begin
			wr(`FND_OFF_MODCFG, cfg(i[1], i[0], 1'b0, 1'b0, 2'd0));
			wait_cycles(2);
			chk({23'h0, mode.mod_on}, 24'(i == 2));
			chk({4'h0, ratio}, 24'h07fffb);
		end
		$display("test modes done");
	endtask

	// Average ratio over a whole dither period gives int plus frac/2^24
	task automatic frac_test();
		int s;
		logic [23:0] f [2] = '{24'h800000, 24'h400000};
		wr(`FND_OFF_INTWORD, 24'd20);
		wr(`FND_OFF_MODCFG, cfg(1'b1, 1'b0, 1'b1, 1'b0, 2'd0));
		for (int k = 0; k < 2; k++) begin
			wr(`FND_OFF_FRAC, f[k]);
			wait_cycles(4);
			s = 0;
			repeat (16) begin
				@(negedge ref_clk);
				s += int'(ratio);
			end
			chk(24'(s), 24'd320 + (f[k] >> 20));
		end
		$display("test fraction done");
	endtask

	task automatic seed_lat(input logic [23:0] c, output int lat);
		wr(`FND_OFF_MODCFG, c);
		wr(`FND_OFF_FRAC, 24'h0);
		wait_cycles(4);
		wr(`FND_OFF_FRAC, 24'h100000);
		lat = 0;
		while (ratio !== 20'd21 && lat < 40) begin
			@(negedge ref_clk);
			lat++;
		end
	endtask

	// Seeds are told apart by when the first carry shows up
	task automatic seed_test();
		int l0, l;
		seed_lat(cfg(1'b1, 1'b0, 1'b1, 1'b0, 2'd0), l0);
		for (int s = 1; s < 4; s++) begin
			seed_lat(cfg(1'b1, 1'b0, 1'b1, 1'b0, 2'(s)), l);
			chk(24'(l - l0), 24'(carry_ticks(seeds[s]) - 16));
		end
		wr(`FND_OFF_MODCFG, cfg(1'b1, 1'b0, 1'b1, 1'b0, 2'd1));
		wr(`FND_OFF_FRAC, 24'h0);
		seed_lat(cfg(1'b1, 1'b0, 1'b0, 1'b0, 2'd0), l);
		chk(24'(l - l0), 24'(carry_ticks(seeds[1]) - 16));
		$display("test seeds done");
	endtask

	task automatic misc_test();
		wr(`FND_OFF_OUTCFG, 24'h080000);
		wait_cycles(2);
		chk({20'h0, mode}, 24'h9);
		wr(`FND_OFF_OUTCFG, 24'h0);
		wr(`FND_OFF_EXACT, 24'h000c00);
		wr(`FND_OFF_MODCFG, cfg(1'b1, 1'b0, 1'b1, 1'b1, 2'd2));
		wait_cycles(2);
		chk({20'h0, mode}, 24'he);
		wr(`FND_OFF_FRAC, 24'h8e2aab);
		rd_chk(`FND_OFF_FRAC, 24'h8e2aab);
		wr(`FND_OFF_MODCFG, cfg(1'b1, 1'b0, 1'b1, 1'b0, 2'd2));
		wait_cycles(2);
		chk({20'h0, mode}, 24'h8);
		$display("test output and exact done");
	endtask

	task automatic enable_test();
		pin = 1'b1;
		wait_cycles(4);
		chk({19'h0, chip_en, pwr}, 24'h1f);
		pin = 1'b0;
		wait_cycles(4);
		chk({19'h0, chip_en, pwr}, 24'h00);
		wr(`FND_OFF_ENABLE, 24'h000002);
		wait_cycles(2);
		chk({19'h0, chip_en, pwr}, 24'h1f);
		wr(`FND_OFF_ENABLE, 24'h000014);
		pin = 1'b1;
		wait_cycles(4);
		chk({19'h0, chip_en, pwr}, 24'h05);
		pin = 1'b0;
		$display("test enable done");
	endtask

	// Third gap is measured, the first may still run on the old count
	task automatic tick_gap(input logic [23:0] r);
		int n;
		wr(`FND_OFF_REFDIV, r);
		n = 0;
		while (tick !== 1'b1 && n < 20000) begin
			@(negedge ref_clk);
			n++;
		end
		repeat (2) begin
			n = 0;
			do begin
				@(negedge ref_clk);
				n++;
			end while (tick !== 1'b1 && n < 20000);
		end
		chk(24'(n), r);
		$display("test tick gap done");
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		por_test();
		reg_test();
		mode_test();
		frac_test();
		seed_test();
		misc_test();
		enable_test();
		tick_gap(24'd3);
		tick_gap(24'h004000);
		por_test();
		tally_and_finish();
	end
endmodule // fnd_divider_ctrl_tb
`default_nettype wire
